// ==== src/feas_pkg.sv ====
// Constants and carriers for the flash embedded algorithm host sequencer
`default_nettype none
package feas_pkg;
	localparam longint CLK_MHZ = 200;
	// Times in their own units
	localparam longint T_WE_LOW_NS = 50;
	localparam longint T_WE_HIGH_NS = 30;
	localparam longint T_READ_NS = 120;
	localparam longint T_RB_WE_NS = 50;
	localparam longint T_RP_ALG_US = 10;
	localparam longint T_RP_IDLE_NS = 500;
	localparam longint T_RDY_ALG_US = 20;
	localparam longint T_RDY_IDLE_NS = 500;
	localparam longint T_RSP_US = 4;
	localparam longint T_VSET_US = 4;
	localparam longint T_PROT_US = 10;
	localparam longint T_UNPROT_MS = 12;
	localparam longint T_PROG_MAX_US = 210;
	localparam longint T_SECT_MAX_MS = 10400;
	localparam longint T_CHIP_MAX_S = 64;
	// Least times round up, longest round down
	localparam logic [31:0] C_WE_LOW = 32'((T_WE_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [31:0] C_WE_HIGH = 32'((T_WE_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [31:0] C_READ = 32'((T_READ_NS * CLK_MHZ + 999) / 1000);
	localparam logic [31:0] C_RB_WE = 32'((T_RB_WE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [31:0] C_RP_ALG = 32'(T_RP_ALG_US * CLK_MHZ);
	localparam logic [31:0] C_RP_IDLE = 32'((T_RP_IDLE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [31:0] C_RDY_ALG = 32'(T_RDY_ALG_US * CLK_MHZ);
	localparam logic [31:0] C_RDY_IDLE = 32'((T_RDY_IDLE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [31:0] C_RSP = 32'(T_RSP_US * CLK_MHZ);
	localparam logic [31:0] C_VSET = 32'(T_VSET_US * CLK_MHZ);
	localparam logic [31:0] C_PROT = 32'(T_PROT_US * CLK_MHZ);
	localparam logic [31:0] C_UNPROT = 32'(T_UNPROT_MS * CLK_MHZ * 1000);
	localparam logic [33:0] C_PROG_TMO = 34'(T_PROG_MAX_US * CLK_MHZ);
	localparam logic [33:0] C_SECT_TMO = 34'(T_SECT_MAX_MS * CLK_MHZ * 1000);
	localparam logic [33:0] C_CHIP_TMO = 34'(T_CHIP_MAX_S * CLK_MHZ * 1000000);
	// Unlock and command codes
	localparam logic [19:0] ADDR_U1 = 20'h00555;
	localparam logic [19:0] ADDR_U2 = 20'h002AA;
	localparam logic [7:0] DAT_U1 = 8'hAA;
	localparam logic [7:0] DAT_U2 = 8'h55;
	localparam logic [7:0] DAT_PROG = 8'hA0;
	localparam logic [7:0] DAT_ERASE = 8'h80;
	localparam logic [7:0] DAT_CHIP = 8'h10;
	localparam logic [7:0] DAT_SECT = 8'h30;
	localparam logic [2:0] STEP_PROG_LAST = 3'h3;
	localparam logic [2:0] STEP_ERASE_LAST = 3'h5;
	localparam int TOG_BIT = 6;
	localparam int POLL_BIT = 7;

	typedef enum logic [2:0] {
		OP_READ   = 3'h0,
		OP_PROG   = 3'h1,
		OP_CHIP   = 3'h2,
		OP_SECT   = 3'h3,
		OP_RESET  = 3'h4,
		OP_PROT   = 3'h5,
		OP_UNPROT = 3'h6,
		OP_TEMP   = 3'h7
	} feas_op_t;

	typedef struct packed {
		feas_op_t    op;
		logic [19:0] addr;
		logic [7:0]  data;
	} feas_cmd_t;

	typedef struct packed {
		logic [19:0] addr;
		logic [7:0]  data;
	} feas_word_t;

	typedef struct packed {
		logic [19:0] addr;
		logic [7:0]  dq_o;
		logic        dq_oe;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        reset_n;
		logic        reset_vid;
		logic        ctrl_vid;
	} feas_pins_t;

	function automatic feas_word_t feas_seq(feas_op_t op, logic [2:0] st, logic [19:0] a,
			logic [7:0] d);
		feas_word_t w;
		w = feas_word_t'{ADDR_U1, DAT_U1};
		case (st)
			3'h1: w = feas_word_t'{ADDR_U2, DAT_U2};
			3'h2: w.data = (op == OP_PROG) ? DAT_PROG : DAT_ERASE;
			3'h3: w = (op == OP_PROG) ? feas_word_t'{a, d} : feas_word_t'{ADDR_U1, DAT_U1};
			3'h4: w = feas_word_t'{ADDR_U2, DAT_U2};
			3'h5: w = (op == OP_CHIP) ? feas_word_t'{ADDR_U1, DAT_CHIP} : feas_word_t'{a, DAT_SECT};
			default: w = feas_word_t'{ADDR_U1, DAT_U1};
		endcase
		return w;
	endfunction
endpackage
`default_nettype wire

// ==== src/feas_host.sv ====
// Host sequencer driving a parallel flash through its pins
`default_nettype none
// Operation
// - Hold reset low 10 us when busy
// - Hold reset low 500 ns when idle
// - Wait 50 ns after ready before write
// - Hold reset at high voltage 4 us before write, until reset command
// - Protect pulse 10 us, unprotect 12 ms
// - Confirm completion by polling, not verify
module feas_host #(
	parameter logic [33:0] P_PROG_TMO = feas_pkg::C_PROG_TMO,
	parameter logic [33:0] P_SECT_TMO = feas_pkg::C_SECT_TMO,
	parameter logic [33:0] P_CHIP_TMO = feas_pkg::C_CHIP_TMO,
	parameter logic [31:0] P_UNPROT   = feas_pkg::C_UNPROT
) (
	// Clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_rst_b,
	// Command port
	input  wire logic                 i_cmd_valid,
	input  wire feas_pkg::feas_cmd_t  i_cmd,
	output logic                      o_cmd_ready,
	output logic                      o_done,
	output logic                      o_error,
	output logic [7:0]                o_rdata,
	// Flash pins
	output feas_pkg::feas_pins_t      o_pins,
	input  wire logic [7:0]           i_dq,
	input  wire logic                 i_ready_busy_n
);
	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_WLO   = 4'h1,
		S_WHI   = 4'h2,
		S_RD    = 4'h3,
		S_RGAP  = 4'h4,
		S_RST   = 4'h5,
		S_RREC  = 4'h6,
		S_VSET  = 4'h7,
		S_PULSE = 4'h8,
		S_TEMP  = 4'h9
	} feas_state_t;

	feas_state_t          st_q, st_d;
	feas_pkg::feas_cmd_t  cmd_q, cmd_d;
	feas_pkg::feas_pins_t pins_q, pins_d;
	feas_pkg::feas_word_t seq_n;
	logic [31:0]          cnt_q, cnt_d, rbc_q, rbc_d, rlen_q, wlen_q, vlen_q;
	logic [33:0]          tmo_q, tmo_d;
	logic [2:0]           step_q, step_d;
	logic [7:0]           dq_s1, dq_s2, rd_q, rd_d, prev_q, prev_d;
	logic [1:0]           have_q, have_d;
	logic                 rb_s1, rb_s2, alg_q, alg_d, temp_q, temp_d;
	logic                 rdy_q, done_d, done_q, err_d, err_q;

	wire        take    = i_cmd_valid && rdy_q;
	wire [2:0]  last    = (cmd_q.op == feas_pkg::OP_PROG) ? feas_pkg::STEP_PROG_LAST
	                                                      : feas_pkg::STEP_ERASE_LAST;
	wire [33:0] tmo_lim = (cmd_q.op == feas_pkg::OP_PROG) ? P_PROG_TMO :
	                      (cmd_q.op == feas_pkg::OP_CHIP) ? P_CHIP_TMO : P_SECT_TMO;
	wire        expect7 = (cmd_q.op == feas_pkg::OP_PROG) ? cmd_q.data[7] : 1'b1;
	wire        tog_eq  = have_q[1] && (rd_q[feas_pkg::TOG_BIT] == prev_q[feas_pkg::TOG_BIT]);
	wire [31:0] rp_len  = alg_q ? feas_pkg::C_RP_ALG : feas_pkg::C_RP_IDLE;
	wire [31:0] rdy_len = alg_q ? feas_pkg::C_RDY_ALG : feas_pkg::C_RDY_IDLE;
	wire [31:0] pw_len  = (cmd_q.op == feas_pkg::OP_UNPROT) ? P_UNPROT : feas_pkg::C_PROT;
	wire        alg_op  = (cmd_q.op == feas_pkg::OP_PROG) || (cmd_q.op == feas_pkg::OP_CHIP)
	                   || (cmd_q.op == feas_pkg::OP_SECT);

	assign seq_n = feas_pkg::feas_seq(cmd_d.op, step_d, cmd_d.addr, cmd_d.data);
	assign rbc_d = !rb_s2 ? 32'h0 : (rbc_q >= feas_pkg::C_RB_WE) ? rbc_q : rbc_q + 32'h1;
	assign o_cmd_ready = rdy_q;
	assign o_done      = done_q;
	assign o_error     = err_q;
	assign o_rdata     = rd_q;
	assign o_pins      = pins_q;
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		cnt_d = cnt_q + 32'h1;
		tmo_d = tmo_q + 34'h1;
		step_d = step_q;
		rd_d = rd_q;
		prev_d = prev_q;
		have_d = have_q;
		alg_d = alg_q;
		temp_d = temp_q;
		done_d = 1'b0;
		err_d = err_q;
		case (st_q)
			S_IDLE: begin
				cnt_d = 32'h0;
				step_d = 3'h0;
				if (take) begin
					cmd_d = i_cmd;
					err_d = 1'b0;
					case (i_cmd.op)
						feas_pkg::OP_READ:   st_d = S_RD;
						feas_pkg::OP_RESET:  st_d = S_RST;
						feas_pkg::OP_PROT:   st_d = S_VSET;
						feas_pkg::OP_UNPROT: st_d = S_VSET;
						feas_pkg::OP_TEMP:   st_d = S_TEMP;
						default:             st_d = S_WLO;
					endcase
					if (i_cmd.op == feas_pkg::OP_RESET)
						temp_d = 1'b0;
					if (i_cmd.op == feas_pkg::OP_TEMP)
						temp_d = 1'b1;
					have_d = 2'h0;
				end
			end
			S_WLO: if (cnt_q >= feas_pkg::C_WE_LOW - 32'h1) begin
				cnt_d = 32'h0;
				st_d = S_WHI;
			end
			S_WHI: if (cnt_q >= feas_pkg::C_WE_HIGH - 32'h1) begin
				cnt_d = 32'h0;
				if (step_q == last) begin
					st_d = S_RD;
					tmo_d = 34'h0;
					alg_d = 1'b1;
				end else begin
					step_d = step_q + 3'h1;
					st_d = S_WLO;
				end
			end
			S_RD: if (cnt_q >= feas_pkg::C_READ - 32'h1) begin
				cnt_d = 32'h0;
				rd_d = dq_s2;
				prev_d = rd_q;
				have_d = {have_q[0], 1'b1};
				st_d = S_RGAP;
			end
			S_RGAP: if (cnt_q >= feas_pkg::C_WE_HIGH - 32'h1) begin
				cnt_d = 32'h0;
				st_d = S_RD;
				if (cmd_q.op == feas_pkg::OP_READ) begin
					st_d = S_IDLE;
					done_d = 1'b1;
				end else if (tog_eq) begin
					// done by toggle bit, poll bit sets error
					st_d = S_IDLE;
					done_d = 1'b1;
					alg_d = 1'b0;
					err_d = rd_q[feas_pkg::POLL_BIT] != expect7;
				end else if (tmo_q >= tmo_lim) begin
					st_d = S_IDLE;
					done_d = 1'b1;
					err_d = 1'b1;
				end
			end
			S_RST: if (cnt_q >= rp_len - 32'h1) begin
				cnt_d = 32'h0;
				st_d = S_RREC;
			end
			S_RREC: if (cnt_q >= rdy_len - 32'h1) begin
				st_d = S_IDLE;
				done_d = 1'b1;
				alg_d = 1'b0;
			end
			S_VSET: if (cnt_q >= feas_pkg::C_VSET - 32'h1) begin
				cnt_d = 32'h0;
				st_d = S_PULSE;
			end
			S_PULSE: if (cnt_q >= pw_len - 32'h1) begin
				st_d = S_IDLE;
				done_d = 1'b1;
			end
			S_TEMP: if (cnt_q >= feas_pkg::C_RSP - 32'h1) begin
				st_d = S_IDLE;
				done_d = 1'b1;
			end
			default: st_d = S_IDLE;
		endcase
	end
	always_comb begin
		pins_d = '{addr: cmd_d.addr, dq_o: seq_n.data, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
			we_n: 1'b1, reset_n: 1'b1, reset_vid: temp_d, ctrl_vid: 1'b0};
		case (st_d)
			S_WLO: begin
				pins_d.addr = seq_n.addr;
				pins_d.dq_oe = 1'b1;
				pins_d.ce_n = 1'b0;
				pins_d.we_n = 1'b0;
			end
			S_WHI: begin
				pins_d.addr = seq_n.addr;
				pins_d.dq_oe = 1'b1;
			end
			S_RD: begin
				pins_d.ce_n = 1'b0;
				pins_d.oe_n = 1'b0;
			end
			S_RST: pins_d.reset_n = 1'b0;
			S_VSET: begin
				pins_d.ctrl_vid = 1'b1;
				pins_d.ce_n = 1'b0;
			end
			S_PULSE: begin
				pins_d.ctrl_vid = 1'b1;
				pins_d.ce_n = 1'b0;
				pins_d.we_n = 1'b0;
			end
			default: pins_d.dq_oe = 1'b0;
		endcase
	end
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= S_IDLE;
			cmd_q <= '0;
			pins_q <= '{addr: 20'h0, dq_o: 8'h0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
				we_n: 1'b1, reset_n: 1'b1, reset_vid: 1'b0, ctrl_vid: 1'b0};
			{cnt_q, rbc_q, tmo_q, step_q} <= '0;
			{dq_s1, dq_s2, rd_q, prev_q, have_q} <= '0;
			{rb_s1, rb_s2, alg_q, temp_q, rdy_q, done_q, err_q} <= '0;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			pins_q <= pins_d;
			{cnt_q, rbc_q, tmo_q, step_q} <= {cnt_d, rbc_d, tmo_d, step_d};
			{dq_s1, dq_s2, rd_q, prev_q, have_q} <= {i_dq, dq_s1, rd_d, prev_d, have_d};
			{rb_s1, rb_s2, alg_q, temp_q} <= {i_ready_busy_n, rb_s1, alg_d, temp_d};
			rdy_q <= (st_d == S_IDLE) && !take && (rbc_d >= feas_pkg::C_RB_WE);
			done_q <= done_d;
			err_q <= err_d;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{rlen_q, wlen_q, vlen_q} <= '0;
		end else begin
			rlen_q <= pins_q.reset_n ? 32'h0 : rlen_q + 32'h1;
			wlen_q <= pins_q.we_n ? 32'h0 : wlen_q + 32'h1;
			vlen_q <= pins_q.reset_vid ? vlen_q + 32'h1 : 32'h0;
		end
	end
	property p_rst_busy;
		@(posedge i_clock) disable iff (!i_rst_b)
		$rose(pins_q.reset_n) && $past(alg_q) |-> rlen_q >= feas_pkg::C_RP_ALG;
	endproperty
	a_rst_busy: assert property (p_rst_busy) else $error("reset pulse too short when busy");
	property p_rst_idle;
		@(posedge i_clock) disable iff (!i_rst_b)
		$rose(pins_q.reset_n) |-> rlen_q >= feas_pkg::C_RP_IDLE;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("reset pulse too short");
	property p_rb_we;
		@(posedge i_clock) disable iff (!i_rst_b)
		$fell(pins_q.we_n) && !pins_q.ctrl_vid |-> rbc_q >= feas_pkg::C_RB_WE;
	endproperty
	a_rb_we: assert property (p_rb_we) else $error("write enable too soon after ready");
	property p_vid_setup;
		@(posedge i_clock) disable iff (!i_rst_b)
		$fell(pins_q.we_n) && pins_q.reset_vid |-> vlen_q >= feas_pkg::C_RSP;
	endproperty
	a_vid_setup: assert property (p_vid_setup) else $error("high voltage setup too short");
	property p_prot_pw;
		@(posedge i_clock) disable iff (!i_rst_b)
		$rose(pins_q.we_n) && $past(pins_q.ctrl_vid) && cmd_q.op == feas_pkg::OP_PROT
			|-> wlen_q >= feas_pkg::C_PROT;
	endproperty
	a_prot_pw: assert property (p_prot_pw) else $error("protect pulse too short");
	property p_unprot_pw;
		@(posedge i_clock) disable iff (!i_rst_b)
		$rose(pins_q.we_n) && $past(pins_q.ctrl_vid) && cmd_q.op == feas_pkg::OP_UNPROT
			|-> wlen_q >= P_UNPROT;
	endproperty
	a_unprot_pw: assert property (p_unprot_pw) else $error("unprotect pulse too short");
	property p_poll_done;
		@(posedge i_clock) disable iff (!i_rst_b)
		done_q && !err_q && alg_op |-> rd_q[feas_pkg::TOG_BIT] == prev_q[feas_pkg::TOG_BIT]
			&& rd_q[feas_pkg::POLL_BIT] == expect7 && !alg_q;
	endproperty
	a_poll_done: assert property (p_poll_done) else $error("completion without polling");
endmodule
`default_nettype wire

// ==== tb/feas_flash_model.sv ====
// Behavioural parallel flash answering the host sequencer
`default_nettype none
module feas_flash_model (
	// Pins from host
	input  wire feas_pkg::feas_pins_t i_pins,
	input  wire logic                 i_slow,
	// Pins to host
	output logic [7:0]                o_dq,
	output logic                      o_ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [logic [19:0]];
	logic [19:0] q_keys [$];
	logic [2:0]  st = 3'h0;
	logic        busy = 1'b0;
	logic        erase = 1'b0;
	logic        whole = 1'b0;
	logic        tog = 1'b0;
	logic [7:0]  pd = 8'h00;
	logic [7:0]  last = 8'h00;
	logic [19:0] pa = 20'h00000;
	logic [3:0]  sect = 4'h0;
	time         t_end = 0;

	assign o_ready_busy_n = !busy;

	task automatic start(input logic er, input time dur);
		busy = 1'b1;
		erase = er;
		t_end = $time + dur;
	endtask

	always @(i_pins or busy or tog) begin
		if (!i_pins.ce_n && !i_pins.oe_n && i_pins.reset_n) begin
			if (busy)
				last = {erase ? 1'b0 : ~pd[7], tog, 6'h00};
			else
				last = mem.exists(i_pins.addr) ? mem[i_pins.addr] : 8'hFF;
			o_dq = last;
		end else
			o_dq = ~last;
	end

	always @(negedge i_pins.oe_n)
		if (busy)
			tog = ~tog;

	// Command sequence decode
	always @(negedge i_pins.we_n) begin
		#1;
		if (!i_pins.ce_n && i_pins.reset_n && !i_pins.ctrl_vid && !busy) begin
			case (st)
				3'h0, 3'h3: st = (i_pins.dq_o == feas_pkg::DAT_U1) ? st + 3'h1 : 3'h0;
				3'h1, 3'h4: st = (i_pins.dq_o == feas_pkg::DAT_U2) ? st + 3'h1 : 3'h0;
				3'h2: begin
					st = (i_pins.dq_o == feas_pkg::DAT_ERASE) ? 3'h3 : 3'h0;
					if (i_pins.dq_o == feas_pkg::DAT_PROG)
						st = 3'h6;
				end
				3'h6: begin
					pa = i_pins.addr;
					pd = i_pins.dq_o;
					start(1'b0, i_slow ? 20000 : 300);
					st = 3'h0;
				end
				default: begin
					whole = (i_pins.dq_o == feas_pkg::DAT_CHIP);
					sect = i_pins.addr[19:16];
					if (whole || i_pins.dq_o == feas_pkg::DAT_SECT)
						start(1'b1, whole ? 2000 : 1900);
					st = 3'h0;
				end
			endcase
		end
	end

	always #5
		if (busy && $time >= t_end) begin
			if (!erase)
				mem[pa] = pd;
			else if (whole)
				mem.delete();
			else begin
				foreach (mem[k])
					if (k[19:16] == sect)
						q_keys.push_back(k);
				foreach (q_keys[i])
					mem.delete(q_keys[i]);
				q_keys.delete();
			end
			busy = 1'b0;
		end

	always @(negedge i_pins.reset_n) begin
		busy = 1'b0;
		st = 3'h0;
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the flash host sequencer
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 i_clock;
	logic                 i_rst_b;
	logic                 i_cmd_valid;
	logic                 slow;
	feas_pkg::feas_cmd_t  i_cmd;
	logic                 o_cmd_ready;
	logic                 o_done;
	logic                 o_error;
	logic [7:0]           o_rdata;
	logic [7:0]           mdq;
	logic [7:0]           i_dq;
	logic                 ready_busy_n;
	feas_pkg::feas_pins_t o_pins;
	int                   errors = 0;
	int                   n_tests = 0;
	int                   seed = 32'hC3AB4454;
	logic [7:0]           exp_mem [logic [19:0]];
	logic [19:0]          a [3];
	logic [7:0]           d;

	assign i_dq = o_pins.dq_oe ? o_pins.dq_o : mdq;

	feas_host #(.P_PROG_TMO(34'h7D0), .P_SECT_TMO(34'hFA0), .P_CHIP_TMO(34'hFA0),
			.P_UNPROT(32'h32)) dut_u (
		.i_clock(i_clock), .i_rst_b(i_rst_b), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
		.o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_error(o_error), .o_rdata(o_rdata),
		.o_pins(o_pins), .i_dq(i_dq), .i_ready_busy_n(ready_busy_n));

	feas_flash_model model_u (.i_pins(o_pins), .i_slow(slow), .o_dq(mdq),
		.o_ready_busy_n(ready_busy_n));

	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	task automatic final_report;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] ex(input logic [19:0] ad);
		return exp_mem.exists(ad) ? exp_mem[ad] : 8'hFF;
	endfunction

	// Issue one command at a falling edge and wait for its end
	task automatic cmd(input feas_pkg::feas_op_t op, input logic [19:0] ad);
		int n;
		i_cmd = '{op, ad, d};
		i_cmd_valid = 1'b1;
		n = 0;
		while (o_cmd_ready !== 1'b1 && n < 20000) begin
			@(negedge i_clock);
			n++;
		end
		@(negedge i_clock);
		i_cmd_valid = 1'b0;
		while (o_done !== 1'b1 && n < 40000) begin
			@(negedge i_clock);
			n++;
		end
		if (n >= 40000)
			errors++;
	endtask

	task automatic read_all;
		foreach (a[i]) begin
			cmd(feas_pkg::OP_READ, a[i]);
			chk8(o_rdata, ex(a[i]));
		end
	endtask

	initial begin
		#200000;
		errors++;
		final_report;
	end

	initial begin
		i_rst_b = 1'b0;
		i_cmd_valid = 1'b0;
		i_cmd = '0;
		slow = 1'b0;
		d = 8'h00;
		repeat (12) @(negedge i_clock);
		chk1(o_cmd_ready, 1'b0);
		i_rst_b = 1'b1;
		cmd(feas_pkg::OP_READ, 20'($random(seed)));
		chk8(o_rdata, 8'hFF);
		for (int i = 0; i < 3; i++) begin
			a[i] = {4'(i), 16'($random(seed))};
			d = 8'($random(seed));
			cmd(feas_pkg::OP_PROG, a[i]);
			exp_mem[a[i]] = d;
			chk1(o_error, 1'b0);
		end
		read_all;
		cmd(feas_pkg::OP_SECT, {4'h1, 16'($random(seed))});
		chk1(o_error, 1'b0);
		exp_mem.delete(a[1]);
		read_all;
		cmd(feas_pkg::OP_CHIP, 20'h00000);
		chk1(o_error, 1'b0);
		exp_mem.delete();
		read_all;
		slow = 1'b1;
		d = 8'h00;
		cmd(feas_pkg::OP_PROG, a[2]);
		chk1(o_error, 1'b1);
		slow = 1'b0;
		exp_mem[a[2]] = d;
		cmd(feas_pkg::OP_RESET, 20'h00000);
		chk1(o_error, 1'b0);
		cmd(feas_pkg::OP_READ, a[2]);
		chk8(o_rdata, ex(a[2]));
		cmd(feas_pkg::OP_RESET, 20'h00000);
		chk1(o_error, 1'b0);
		cmd(feas_pkg::OP_PROT, a[0]);
		chk1(o_error, 1'b0);
		cmd(feas_pkg::OP_UNPROT, a[0]);
		chk1(o_error, 1'b0);
		cmd(feas_pkg::OP_TEMP, a[0]);
		chk1(o_error, 1'b0);
		d = 8'($random(seed));
		cmd(feas_pkg::OP_PROG, a[0]);
		exp_mem[a[0]] = d;
		chk1(o_error, 1'b0);
		cmd(feas_pkg::OP_RESET, 20'h00000);
		chk1(o_error, 1'b0);
		read_all;
		final_report;
	end
endmodule
`default_nettype wire
